// ### hw/remote_run_sync_pkg.sv
// remote_run_sync_pkg: timing counts, states and grouped signals for the remote run sync block
// assumes a 250 MHz mclk; all counts derive from the times below
package remote_run_sync_pkg;

  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned MAX_NODES       = 10;            // instruments that may share the bus
  localparam int unsigned START_MIN_US    = 500;           // least recognised start width
  localparam int unsigned CONTACT_MS      = 120;           // start contact closure time
  localparam int unsigned START_MIN_CYC   = START_MIN_US * CLK_MHZ;            // 125000, least: exact
  localparam int unsigned CONTACT_CYC     = CONTACT_MS * 1000 * CLK_MHZ;      // 30000000
  localparam int unsigned CNT_W           = 25;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PREP    = 3'b001,
    ST_READY   = 3'b010,
    ST_RUN     = 3'b011,
    ST_STOPPING= 3'b100
  } run_state_t;

  // bus lines as seen by the instrument, all levels high = released
  typedef struct packed {
    logic prep_n;
    logic start_n;
    logic stop_n;
    logic ready;
  } bus_lines_t;

endpackage

// ### hw/remote_run_sync.sv
// remote_run_sync: prepare/start/stop/ready handling on a shared open-drain remote bus
// assumes pins are open drain with external pull-ups; outputs only ever pull low
`timescale 1ns/1ns
module remote_run_sync #(
  parameter int unsigned START_MIN = remote_run_sync_pkg::START_MIN_CYC,
  parameter int unsigned CONTACT   = remote_run_sync_pkg::CONTACT_CYC
) (
  input  wire logic                             mclk,
  input  wire logic                             rst,
  input  wire remote_run_sync_pkg::bus_lines_t  bus_i,
  output      remote_run_sync_pkg::bus_lines_t  bus_o,
  output      remote_run_sync_pkg::bus_lines_t  bus_oe,
  input  wire logic                             local_prep,
  input  wire logic                             local_start,
  input  wire logic                             local_stop,
  input  wire logic                             prep_done,
  input  wire logic                             run_done,
  input  wire logic                             not_ready_cond,
  output      logic                             contact_closed,
  output      logic                             prep_active,
  output      logic                             run_active,
  output      logic                             timetable_go,
  output      logic                             abort_pulse,
  output      logic                             inst_ready
);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: first flop feeds only the second
  // every bus line is driven by other instruments on their own clocks, so all
  // four pass two flops before any edge detect, width count or state change
  // reset value is all ones, the released level, so no false edge follows reset
  // the ready bit is synced as well although only a sequence controller reads it
  remote_run_sync_pkg::bus_lines_t sync1_q;
  remote_run_sync_pkg::bus_lines_t sync2_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= bus_i;
      sync2_q <= sync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start qualification: a glitch shorter than the least width never starts a run
  // the counter runs only while the synced line is low and clears on release,
  // so a train of short glitches never adds up to a start
  // start_full marks the last needed low sample; start_seen_q then blocks a
  // second event until the line has been released again
  // limitation: one released sample in the middle restarts the whole count
  logic [remote_run_sync_pkg::CNT_W-1:0] slow_q;
  logic                                  start_seen_q;
  wire                                   start_low  = ~sync2_q.start_n;
  wire                                   start_full = (slow_q == START_MIN[remote_run_sync_pkg::CNT_W-1:0] - 25'h0000001);
  wire                                   start_evt  = start_low && start_full && !start_seen_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slow_q       <= 25'h0000000;
      start_seen_q <= 1'b0;
    end else if (!start_low) begin
      slow_q       <= 25'h0000000;
      start_seen_q <= 1'b0;
    end else if (!start_full) begin
      slow_q <= slow_q + 25'h0000001;
    end else begin
      start_seen_q <= 1'b1; // one event per low pulse
    end
  end

  // prepare and stop act on the synchronised level, falling edge only
  // no width qualification here: one synced low sample is enough, which trades
  // glitch immunity for the quickest possible stop
  // the delay flops reset high, the idle level of the lines
  logic prep_d1_q;
  logic stop_d1_q;
  wire  prep_evt = ~sync2_q.prep_n & prep_d1_q;
  wire  stop_evt = ~sync2_q.stop_n & stop_d1_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prep_d1_q <= 1'b1;
      stop_d1_q <= 1'b1;
    end else begin
      prep_d1_q <= sync2_q.prep_n;
      stop_d1_q <= sync2_q.stop_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // own requests: hold the line low for the least width, then release
  // each line has its own down counter loaded with the least start width, so a
  // peer that qualifies with the same width still sees a full request
  // a request that comes while its line is still driven is dropped, not queued
  // own drives come back on bus_i through the wired-or and so act here as well
  logic [remote_run_sync_pkg::CNT_W-1:0] drv_cnt_q [3];
  wire  [2:0]                            req = {local_stop, local_start, local_prep};
  logic [2:0]                            drv_on;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_drv
      assign drv_on[g] = (drv_cnt_q[g] != 25'h0000000);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          drv_cnt_q[g] <= 25'h0000000;
        end else if (req[g] && !drv_on[g]) begin
          drv_cnt_q[g] <= START_MIN[remote_run_sync_pkg::CNT_W-1:0];
        end else if (drv_on[g]) begin
          drv_cnt_q[g] <= drv_cnt_q[g] - 25'h0000001;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // run state machine; stop outranks start, start outranks prepare
  // idle means not ready; ready and prep accept a start; a run ends on stop or
  // when the local oven program raises run_done
  // stopping lasts one cycle and raises abort_pulse to halt any injection
  // a start seen in idle or run is ignored, as is a prepare outside ready
  remote_run_sync_pkg::run_state_t st_q;
  remote_run_sync_pkg::run_state_t st_d;
  logic                            go_d;

  always_comb begin
    st_d = st_q;
    go_d = 1'b0;
    case (st_q)
      remote_run_sync_pkg::ST_IDLE: begin
        if (!not_ready_cond) st_d = remote_run_sync_pkg::ST_READY;
      end
      remote_run_sync_pkg::ST_READY: begin
        if (stop_evt) st_d = remote_run_sync_pkg::ST_READY;
        else if (start_evt) begin
          st_d = remote_run_sync_pkg::ST_RUN;
          go_d = 1'b1;
        end else if (prep_evt) st_d = remote_run_sync_pkg::ST_PREP;
        else if (not_ready_cond) st_d = remote_run_sync_pkg::ST_IDLE;
      end
      remote_run_sync_pkg::ST_PREP: begin
        if (stop_evt) st_d = remote_run_sync_pkg::ST_STOPPING;
        else if (start_evt) begin
          st_d = remote_run_sync_pkg::ST_RUN;
          go_d = 1'b1;
        end
      end
      remote_run_sync_pkg::ST_RUN: begin
        if (stop_evt) st_d = remote_run_sync_pkg::ST_STOPPING;
        else if (run_done) st_d = remote_run_sync_pkg::ST_IDLE;
      end
      remote_run_sync_pkg::ST_STOPPING: st_d = remote_run_sync_pkg::ST_IDLE;
      default: st_d = remote_run_sync_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q         <= remote_run_sync_pkg::ST_IDLE;
      timetable_go <= 1'b0;
      abort_pulse  <= 1'b0;
    end else begin
      st_q         <= st_d;
      timetable_go <= go_d;
      abort_pulse  <= (st_d == remote_run_sync_pkg::ST_STOPPING);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start contact: retriggers on each start, opens after the closure time
  // the closure time is counted in mclk cycles; a new start reloads the count
  // so back-to-back runs keep the contact closed instead of chattering
  logic [remote_run_sync_pkg::CNT_W-1:0] cont_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cont_q <= 25'h0000000;
    end else if (go_d) begin
      cont_q <= CONTACT[remote_run_sync_pkg::CNT_W-1:0];
    end else if (cont_q != 25'h0000000) begin
      cont_q <= cont_q - 25'h0000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status outputs and open-drain drive; data pins only ever carry zero
  // status is registered from the next state or the contact count, so it moves with st_q and never
  // glitches; ready is released in ready and prep only, and in idle, run and
  // stopping the line is pulled low so a sequence controller waits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      contact_closed <= 1'b0;
      prep_active    <= 1'b0;
      run_active     <= 1'b0;
      inst_ready     <= 1'b0;
    end else begin
      contact_closed <= (cont_q != 25'h0000000) || go_d;
      prep_active    <= (st_d == remote_run_sync_pkg::ST_PREP) && !prep_done;
      run_active     <= (st_d == remote_run_sync_pkg::ST_RUN);
      inst_ready     <= (st_d == remote_run_sync_pkg::ST_READY) || (st_d == remote_run_sync_pkg::ST_PREP);
    end
  end

  // open drain: data is always zero and the enable decides the line; the
  // concatenation follows the struct order prepare, start, stop, ready
  // the bus is wired-or, so every instrument up to the shared limit may sink a
  // line at once without contention
  assign bus_o  = 4'h0;
  assign bus_oe = {drv_on[0], drv_on[1], drv_on[2], ~inst_ready};

endmodule

// ### verif/remote_peer.sv
// remote_peer: other instruments on the shared remote bus, plus the pull-ups
// assumes the bench asks for pulls; the peer only ever sinks a line
`timescale 1ns/1ns
module remote_peer (
  input  wire remote_run_sync_pkg::bus_lines_t dut_oe,
  input  wire remote_run_sync_pkg::bus_lines_t pull,
  output wire remote_run_sync_pkg::bus_lines_t bus
);
  // wired-or low: any sink wins, otherwise the pull-up shows high
  // stop stays released unless a scenario asks, as when a test aborts the run
  assign bus = ~(dut_oe | pull);
endmodule

// ### verif/remote_run_sync_sva.sv
// remote_run_sync_sva: timing checks on the remote run sync ports
// assumes short sim counts handed on by the bind
`timescale 1ns/1ns
module remote_run_sync_sva #(
  parameter int unsigned START_MIN = 8,
  parameter int unsigned CONTACT   = 20
) (
  input wire logic                            mclk,
  input wire logic                            rst,
  input wire remote_run_sync_pkg::bus_lines_t bus_i,
  input wire remote_run_sync_pkg::bus_lines_t bus_o,
  input wire remote_run_sync_pkg::bus_lines_t bus_oe,
  input wire logic                            contact_closed,
  input wire logic                            prep_active,
  input wire logic                            run_active,
  input wire logic                            timetable_go,
  input wire logic                            abort_pulse,
  input wire logic                            inst_ready
);
  int unsigned lo_q;
  int unsigned wid_q;
  int unsigned cc_q;
  // low width is kept after release, since the run starts a few cycles late
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lo_q <= 0;
      wid_q <= 0;
      cc_q <= 0;
    end else begin
      lo_q <= bus_i.start_n ? 0 : lo_q + 1;
      wid_q <= (bus_i.start_n && lo_q != 0) ? lo_q : wid_q;
      cc_q <= contact_closed ? cc_q + 1 : 0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  open_drain_a: assert property (bus_o == 4'h0) else $error("bus data not low");
  ready_line_a: assert property (inst_ready [*2] |-> !bus_oe.ready) else $error("ready pulled");
  run_ready_a: assert property (run_active |-> !inst_ready) else $error("ready in run");
  go_pulse_a: assert property (timetable_go |=> !timetable_go) else $error("go too long");
  go_run_a: assert property (timetable_go |-> run_active && contact_closed) else $error("go alone");
  start_width_a: assert property (timetable_go |-> (lo_q >= START_MIN || wid_q >= START_MIN))
    else $error("short start taken");
  contact_len_a: assert property ($fell(contact_closed) |-> cc_q >= CONTACT) else $error("contact short");
  stop_abort_a: assert property (abort_pulse |-> ##[0:2] !run_active) else $error("run kept");
  prep_sync_a: assert property ($rose(prep_active) |-> !$past(bus_i.prep_n, 2)) else $error("prep unsynced");
  own_start_a: assert property ($rose(bus_oe.start_n) |-> bus_oe.start_n [*8] ##1 !bus_oe.start_n)
    else $error("own start width");
  cover property (timetable_go);
  cover property (abort_pulse);
  cover property ($rose(prep_active));
  cover property ($rose(bus_oe.prep_n));
endmodule
bind remote_run_sync remote_run_sync_sva #(.START_MIN(START_MIN), .CONTACT(CONTACT)) u_remote_run_sync_sva (
  .mclk, .rst, .bus_i, .bus_o, .bus_oe, .contact_closed, .prep_active, .run_active, .timetable_go,
  .abort_pulse, .inst_ready);

// ### verif/tb_top.sv
// tb_top: directed scenarios for the remote run sync block
// assumes short counts START_MIN 8 and CONTACT 20
`timescale 1ns/1ns
module tb_top;
  logic mclk, rst, l_prep, l_start, l_stop, prep_done, run_done, nrdy;
  remote_run_sync_pkg::bus_lines_t pull, oe, bw;
  wire logic contact_closed, prep_active, run_active, timetable_go, abort_pulse, inst_ready;
  int failures, compares, cyc, n;
  remote_peer u_remote_peer (.dut_oe(oe), .pull(pull), .bus(bw));
  remote_run_sync #(.START_MIN(8), .CONTACT(20)) u_remote_run_sync (.mclk(mclk), .rst(rst), .bus_i(bw),
    .bus_o(), .bus_oe(oe), .local_prep(l_prep), .local_start(l_start), .local_stop(l_stop),
    .prep_done(prep_done), .run_done(run_done), .not_ready_cond(nrdy), .contact_closed(contact_closed),
    .prep_active(prep_active), .run_active(run_active), .timetable_go(timetable_go),
    .abort_pulse(abort_pulse), .inst_ready(inst_ready));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic seen, input logic exp, input string m);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a peer sinks one line for k cycles, driven off the falling edge
  task automatic sink(input int b, input int k);
    pull[b] = 1'b1;
    repeat (k) @(negedge mclk);
    pull[b] = 1'b0;
  endtask
  task automatic t_short();
    sink(2, 5);
    repeat (15) @(negedge mclk);
    check(run_active, 1'b0, "short start ran");
    check(inst_ready, 1'b1, "not ready after reset");
    $display("test short start done");
  endtask
  task automatic t_run();
    sink(3, 4);
    repeat (2) @(negedge mclk);
    check(prep_active, 1'b1, "no prep");
    sink(2, 10);
    for (n = 0; n < 30 && timetable_go !== 1'b1; n++) @(negedge mclk);
    check(run_active & contact_closed, 1'b1, "run not begun");
    check(inst_ready, 1'b0, "ready in run");
    for (n = 0; n < 40 && contact_closed === 1'b1; n++) @(negedge mclk);
    check(n >= 20 && n < 23, 1'b1, "contact time");
    // hold stop while watching, the abort pulse stands one cycle only
    pull[1] = 1'b1;
    for (n = 0; n < 20 && abort_pulse !== 1'b1; n++) @(negedge mclk);
    check(abort_pulse, 1'b1, "no abort");
    repeat (2) @(negedge mclk);
    pull[1] = 1'b0;
    repeat (8) @(negedge mclk);
    check(run_active | ~inst_ready, 1'b0, "stop not ready");
    $display("test prep run stop done");
  endtask
  task automatic t_own();
    l_start = 1'b1;
    @(negedge mclk);
    l_start = 1'b0;
    @(negedge mclk);
    check(oe.start_n & ~bw.start_n, 1'b1, "own start not driven");
    for (n = 0; n < 40 && timetable_go !== 1'b1; n++) @(negedge mclk);
    check(run_active, 1'b1, "own start no run");
    run_done = 1'b1;
    repeat (6) @(negedge mclk);
    run_done = 1'b0;
    check(inst_ready, 1'b1, "run end not ready");
    $display("test own start done");
  endtask
  // not ready pulls the ready line and refuses a start; own prepare, then own stop
  task automatic t_ready();
    nrdy = 1'b1;
    repeat (3) @(negedge mclk);
    check(inst_ready, 1'b0, "ready while not ready");
    check(bw.ready, 1'b0, "ready line released");
    sink(2, 10);
    repeat (4) @(negedge mclk);
    check(run_active, 1'b0, "start taken when not ready");
    nrdy = 1'b0;
    repeat (3) @(negedge mclk);
    check(bw.ready & inst_ready, 1'b1, "ready line held low");
    l_prep = 1'b1;
    @(negedge mclk);
    l_prep = 1'b0;
    @(negedge mclk);
    check(oe.prep_n & ~bw.prep_n, 1'b1, "own prep not driven");
    repeat (5) @(negedge mclk);
    check(prep_active, 1'b1, "own prep not taken");
    @(negedge mclk);
    check(oe.prep_n, 1'b1, "own prep short");
    repeat (2) @(negedge mclk);
    check(bw.prep_n, 1'b1, "own prep not released");
    prep_done = 1'b1;
    repeat (2) @(negedge mclk);
    check(prep_active, 1'b0, "prep not done");
    l_stop = 1'b1;
    @(negedge mclk);
    l_stop = 1'b0;
    for (n = 0; n < 20 && abort_pulse !== 1'b1; n++) @(negedge mclk);
    check(abort_pulse, 1'b1, "own stop no abort");
    prep_done = 1'b0;
    repeat (4) @(negedge mclk);
    check(inst_ready & ~prep_active, 1'b1, "own stop not ready");
    $display("test ready and own prep stop done");
  endtask
  // cycle ceiling well above the roughly 140 cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {rst, l_prep, l_start, l_stop, prep_done, run_done, nrdy} = 7'h40;
    pull = 4'h0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    t_short();
    t_run();
    t_own();
    t_ready();
    print_verdict();
  end
endmodule
